// ==== blc_sensor.sv ====
// Purpose: sensor end: serial register port and black-level calibration
// Assumes: pixels arrive in order, one column of a kernel per valid
// Notes: the serial port is oversampled by clk_i, no clock from the link
// What this block does
// - generate programmed black lines every frame
// - host programs one to 255 lines
// - each black line holds 80 kernels
// - gated leading lines blanked, not calibrated
// - host keeps two lines when gating
// - auto mode computes and applies offsets
// - black pixels always leave uncorrected
// - manual offset applied equally to all non-black pixels
// - all-ones offset freezes factors in auto
// - sign bit adds or subtracts in manual
// - low-pass filter over two-power samples
// - flag each path short of samples
// - statistics capped at half the kernels
// - serial port timed by master clock
// - nine address bits, sixteen data bits
// - select, wait one period, address msb first
// - mosi changes falling, sampled rising
// - command bit: high writes, low reads
// - write data follows, msb first
// - read data out msb first, sampled falling
// - deselect one period after last bit
// - two periods deselected between accesses
// - sixty-four column offsets, one per column
`timescale 1ns/1ps
module blc_sensor (
  input wire logic clk_i,
  input wire logic rst_i,
  blc_spi_if.device spi,
  input wire logic frame_start_i,
  input wire logic pix_valid_i,
  input wire logic [blc_pkg::PIX_W-1:0] pix_i,
  output logic pix_valid_o,
  output logic [blc_pkg::PIX_W-1:0] pix_o,
  output logic black_line_o,
  output logic blank_o
);
  import blc_pkg::*;
  // ==========================================================
  // serial input resynchronisers
  logic [2:0] sck_s, ss_s, mosi_s;  // stage 0 feeds stage 1 only
  logic sck_l, ss_l, mosi_l;        // agreed levels
  logic sck_rise, sck_fall, sel;
  // three stages, a level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_s <= 3'h0;
      ss_s <= 3'h7;
      mosi_s <= 3'h0;
    end else begin
      sck_s <= {sck_s[1:0], spi.sck};
      ss_s <= {ss_s[1:0], spi.ss_n};
      mosi_s <= {mosi_s[1:0], spi.mosi};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_l <= 1'b0;
      ss_l <= 1'b1;
      mosi_l <= 1'b0;
    end else begin
      if (sck_s[1] == sck_s[2])
        sck_l <= sck_s[2];
      if (ss_s[1] == ss_s[2])
        ss_l <= ss_s[2];
      if (mosi_s[1] == mosi_s[2])
        mosi_l <= mosi_s[2];
    end
  end
  // edges of the master clock, seen by clk_i
  assign sck_rise = (sck_s[1] == sck_s[2]) & sck_s[2] & ~sck_l;
  assign sck_fall = (sck_s[1] == sck_s[2]) & ~sck_s[2] & sck_l;
  assign sel = ~ss_l;
  // ==========================================================
  // serial frame decode
  logic [4:0] bit_cnt;      // rising edges seen this frame
  logic [8:0] addr_reg;     // shifted-in address
  logic cmd_reg;            // high for write
  logic [15:0] wsh_reg;     // write data shift
  logic [15:0] rsh_reg;     // read data shift
  logic rd_act;             // miso driven
  logic [15:0] rd_data;
  logic wr_go;
  logic [15:0] wr_word;
  // last write bit completes the word
  assign wr_go = sel & sck_rise & cmd_reg & (bit_cnt == 5'(FRAME_BITS - 1));
  assign wr_word = {wsh_reg[14:0], mosi_l};
  // deselect aborts any partial frame
  always_ff @(posedge clk_i) begin
    if (rst_i || !sel) begin
      bit_cnt <= 5'h0;
      rd_act <= 1'b0;
      addr_reg <= 9'h0;
      cmd_reg <= 1'b0;
      wsh_reg <= 16'h0;
      rsh_reg <= 16'h0;
    end else if (sck_rise) begin
      if (bit_cnt < 5'(FRAME_BITS))
        bit_cnt <= bit_cnt + 5'h1;
      if (bit_cnt < 5'(CMD_BIT)) begin
        addr_reg <= {addr_reg[7:0], mosi_l};
      end else if (bit_cnt == 5'(CMD_BIT)) begin
        cmd_reg <= mosi_l;
        if (!mosi_l) begin
          rsh_reg <= rd_data;  // msb ready before the first sample
          rd_act <= 1'b1;
        end
      end else if (cmd_reg) begin
        wsh_reg <= wr_word;
      end
    end else if (sck_fall && rd_act && bit_cnt >= 5'(RD_FIRST_FALL)) begin
      rsh_reg <= {rsh_reg[14:0], 1'b0};
    end
  end
  assign spi.miso = rsh_reg[15];
  assign spi.miso_oe_n = ~rd_act;
  // ==========================================================
  // configuration registers
  logic [15:0] filt_reg, offs_reg, lines_reg;
  logic [63:0] err_reg;  // one flag per column path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_reg <= FILT_RST;
      offs_reg <= OFFS_RST;
      lines_reg <= LINES_RST;
    end else if (wr_go) begin
      unique case (addr_reg)
        REG_FILT: filt_reg <= wr_word;
        REG_OFFS: offs_reg <= wr_word;
        REG_LINES: lines_reg <= wr_word;
        default: ;  // read-only or unmapped: ignored
      endcase
    end
  end
  // read mux, unmapped reads zero
  always_comb begin
    unique case (addr_reg)
      REG_FILT: rd_data = filt_reg;
      REG_OFFS: rd_data = offs_reg;
      REG_ERR0: rd_data = err_reg[15:0];
      REG_ERR1: rd_data = err_reg[31:16];
      REG_ERR2: rd_data = err_reg[47:32];
      REG_ERR3: rd_data = err_reg[63:48];
      REG_LINES: rd_data = lines_reg;
      default: rd_data = 16'h0;
    endcase
  end
  // field views
  logic [7:0] n_lines;
  logic [4:0] n_gate;
  logic auto_en, dec, freeze;
  logic [8:0] man_off;
  logic [2:0] n_samp;
  assign n_lines = lines_reg[LINES_HI:LINES_LO];
  assign n_gate = lines_reg[GATE_HI:GATE_LO];
  assign auto_en = offs_reg[AUTO_BIT];
  assign man_off = offs_reg[OFFS_HI:OFFS_LO];
  assign dec = offs_reg[DEC_BIT];
  assign n_samp = filt_reg[SAMP_HI:SAMP_LO];
  assign freeze = auto_en & (man_off == FREEZE_CODE);
  // ==========================================================
  // frame position
  logic [5:0] col_reg;
  logic [6:0] kern_reg;
  logic [7:0] line_reg;
  logic black_reg;
  logic black_end, gated, use_smp;
  assign black_end = pix_valid_i & black_reg & (&col_reg) &
                     (kern_reg == 7'(KERNELS - 1)) & (line_reg == n_lines - 8'h1);
  assign gated = line_reg < {3'h0, n_gate};
  assign use_smp = pix_valid_i & black_reg & ~gated;
  // black lines open each frame, each 80 kernels of 64 columns
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      col_reg <= 6'h0;
      kern_reg <= 7'h0;
      line_reg <= 8'h0;
      black_reg <= 1'b0;
    end else if (frame_start_i) begin
      col_reg <= 6'h0;
      kern_reg <= 7'h0;
      line_reg <= 8'h0;
      black_reg <= n_lines != 8'h0;
    end else if (pix_valid_i) begin
      col_reg <= col_reg + 6'h1;
      if (&col_reg) begin
        if (kern_reg == 7'(KERNELS - 1)) begin
          kern_reg <= 7'h0;
          if (black_reg)
            line_reg <= line_reg + 8'h1;
        end else begin
          kern_reg <= kern_reg + 7'h1;
        end
      end
      if (black_end)
        black_reg <= 1'b0;
    end
  end

  // ==========================================================
  // per-column filter
  logic [5:0] cnt_mem [COLS];    // usable samples this frame
  logic [15:0] avg_mem [COLS];   // filtered black level, 10.6
  logic signed [16:0] diff, step;
  logic signed [17:0] sum;
  logic [5:0] cnt_cur;
  logic eval_reg;                // flags taken one cycle after last black pixel
  assign cnt_cur = cnt_mem[col_reg];
  assign diff = $signed({1'b0, pix_i, 6'h0}) - $signed({1'b0, avg_mem[col_reg]});
  assign step = diff >>> n_samp;
  assign sum = $signed({2'b0, avg_mem[col_reg]}) + 18'(step);
  // sample counts, capped at half the kernels
  always_ff @(posedge clk_i) begin
    if (rst_i || frame_start_i) begin
      for (int i = 0; i < COLS; i++)
        cnt_mem[i] <= 6'h0;
    end else if (use_smp && cnt_cur < HALF_KERN) begin
      cnt_mem[col_reg] <= cnt_cur + 6'h1;
    end
  end
  // running average per column, held while frozen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < COLS; i++)
        avg_mem[i] <= 16'h0;
    end else if (use_smp && auto_en && !freeze && cnt_cur < HALF_KERN) begin
      avg_mem[col_reg] <= sum[15:0];
    end
  end
  // shortage flags recomputed each frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eval_reg <= 1'b0;
      err_reg <= 64'h0;
    end else begin
      eval_reg <= black_end;
      if (eval_reg) begin
        for (int i = 0; i < COLS; i++)
          err_reg[i] <= auto_en & ((8'h01 << n_samp) > {2'h0, cnt_mem[i]});
      end
    end
  end

  // ==========================================================
  // pixel correction
  logic signed [11:0] corr;
  logic [9:0] corr_clip;
  always_comb begin
    if (auto_en)
      corr = $signed({2'h0, pix_i}) - $signed({2'h0, avg_mem[col_reg][15:FRAC_W]});
    else if (dec)
      corr = $signed({2'h0, pix_i}) - $signed({3'h0, man_off});
    else
      corr = $signed({2'h0, pix_i}) + $signed({3'h0, man_off});
    if (corr < 0)
      corr_clip = 10'h0;
    else if (corr > $signed({2'h0, PIX_MAX}))
      corr_clip = PIX_MAX;
    else
      corr_clip = corr[9:0];
  end
  // registered output: raw black, zero for gated lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_valid_o <= 1'b0;
      pix_o <= 10'h0;
      black_line_o <= 1'b0;
      blank_o <= 1'b0;
    end else begin
      pix_valid_o <= pix_valid_i;
      black_line_o <= pix_valid_i & black_reg;
      blank_o <= pix_valid_i & black_reg & gated;
      if (black_reg)
        pix_o <= gated ? 10'h0 : pix_i;
      else
        pix_o <= corr_clip;
    end
  end
endmodule : blc_sensor

// ==== blc_pkg.sv ====
// Purpose: shared constants for the black-level calibration block and its serial port
// Assumes: 9-bit register addresses, 16-bit register words
// Notes: both ends of the serial link import this package
package blc_pkg;
  // ==========================================================
  // serial frame layout
  localparam int ADDR_W = 9;           // register address bits
  localparam int DATA_W = 16;          // register data bits
  localparam int CMD_BIT = 9;          // rise index of the write/read bit
  localparam int FRAME_BITS = 26;      // address + command + data
  localparam int RD_FIRST_FALL = 11;   // first falling edge the master samples miso
  // ==========================================================
  // register map
  localparam logic [8:0] REG_FILT = 9'h080;   // black_filter_config
  localparam logic [8:0] REG_OFFS = 9'h081;   // black_offset_control
  localparam logic [8:0] REG_ERR0 = 9'h088;   // black_shortage_flags_0
  localparam logic [8:0] REG_ERR1 = 9'h089;   // black_shortage_flags_1
  localparam logic [8:0] REG_ERR2 = 9'h08a;   // black_shortage_flags_2
  localparam logic [8:0] REG_ERR3 = 9'h08b;   // black_shortage_flags_3
  localparam logic [8:0] REG_LINES = 9'h0c5;  // black_line_config
  localparam logic [15:0] FILT_RST = 16'h0300;   // eight samples
  localparam logic [15:0] OFFS_RST = 16'h0001;   // auto mode on
  localparam logic [15:0] LINES_RST = 16'h0108;  // eight lines, first gated
  // ==========================================================
  // field positions
  localparam int LINES_HI = 7;
  localparam int LINES_LO = 0;
  localparam int GATE_HI = 12;
  localparam int GATE_LO = 8;
  localparam int AUTO_BIT = 0;
  localparam int OFFS_HI = 9;
  localparam int OFFS_LO = 1;
  localparam int DEC_BIT = 10;
  localparam int SAMP_HI = 10;
  localparam int SAMP_LO = 8;
  localparam logic [8:0] FREEZE_CODE = 9'h1ff;
  // ==========================================================
  // pixel geometry and filter
  localparam int PIX_W = 10;
  localparam int COLS = 64;            // columns in one kernel
  localparam int KERNELS = 80;         // kernels in one line
  localparam logic [5:0] HALF_KERN = 6'h28;  // statistics cap, half the kernels
  localparam int FRAC_W = 6;           // fraction bits of the averages
  localparam logic [9:0] PIX_MAX = 10'h3ff;
  // ==========================================================
  // host controller
  localparam int SCK_HALF = 4;         // clk cycles per sck half period
  localparam int LEAD_HALVES = 2;      // select to first bit
  localparam int TAIL_HALVES = 2;      // last bit to deselect
  localparam int GAP_HALVES = 4;       // deselected time between accesses
  localparam logic [3:0] WB_CMD = 4'h0;
  localparam logic [3:0] WB_WDATA = 4'h4;
  localparam logic [3:0] WB_RDATA = 4'h8;
  localparam logic [3:0] WB_STATUS = 4'hc;
  localparam int CMD_WE_BIT = 9;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
endpackage : blc_pkg

// ==== blc_spi_if.sv ====
// Purpose: four-wire serial link between host controller and sensor
// Assumes: miso is driven only while its enable is low
// Notes: the undriven miso line reads as zero
`timescale 1ns/1ps
interface blc_spi_if;
  // ==========================================================
  // wires
  logic sck;        // serial clock from the host
  logic ss_n;       // select, active low
  logic mosi;       // host to sensor data
  logic miso;       // sensor output value
  logic miso_oe_n;  // sensor output enable, active low
  logic miso_line;  // resolved line level
  assign miso_line = miso_oe_n ? 1'b0 : miso;
  modport device (input sck, input ss_n, input mosi, output miso, output miso_oe_n);
  modport host (output sck, output ss_n, output mosi, input miso_line);
endinterface : blc_spi_if

// ==== blc_host.sv ====
// Purpose: host controller, serial master driven by wishbone registers
// Assumes: single wishbone master, classic cycles
// Notes: sck comes from a divider of clk_i; miso is resynchronised
`timescale 1ns/1ps
module blc_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  blc_spi_if.host spi
);
  import blc_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_LEAD = 3'b001, H_BITS = 3'b010, H_TAIL = 3'b011, H_GAP = 3'b100
  } blc_hstate_e;

  // ==========================================================
  // wishbone slave
  logic ack_reg;                 // one cycle answer
  logic [31:0] dat_reg;          // read data
  logic [9:0] cmd_reg;           // address and write flag
  logic [15:0] wdata_reg;        // word to send
  logic [15:0] rdata_reg;        // word received
  logic done_reg;                // sticky end of access
  blc_hstate_e st_reg;
  logic wr_acc;
  logic start;

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  // write lands at the edge where ack is seen high
  assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  // a command while busy is dropped
  assign start = wr_acc & (wb_adr_i == WB_CMD) & (st_reg == H_IDLE) & (&wb_sel_i[1:0]);

  // ack and read mux, answer after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      unique case (wb_adr_i)
        WB_CMD: dat_reg <= {22'h0, cmd_reg};
        WB_WDATA: dat_reg <= {16'h0, wdata_reg};
        WB_RDATA: dat_reg <= {16'h0, rdata_reg};
        WB_STATUS: dat_reg <= {30'h0, done_reg, st_reg != H_IDLE};
        default: dat_reg <= 32'h0;  // unmapped reads zero
      endcase
    end
  end

  // software registers, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= 10'h0;
      wdata_reg <= 16'h0;
    end else begin
      if (start)
        cmd_reg <= wb_dat_i[9:0];
      if (wr_acc && wb_adr_i == WB_WDATA) begin
        if (wb_sel_i[0])
          wdata_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          wdata_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ==========================================================
  // miso resynchroniser, three stages, level taken when two agree
  logic [2:0] miso_s;
  logic miso_l;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miso_s <= 3'h0;
      miso_l <= 1'b0;
    end else begin
      miso_s <= {miso_s[1:0], spi.miso_line};
      if (miso_s[1] == miso_s[2])
        miso_l <= miso_s[2];
    end
  end

  // agreed level, usable at the very edge where stages two and three match;
  // the registered level lags a cycle and would take the previous bit at full rate
  logic miso_ag;
  assign miso_ag = (miso_s[1] == miso_s[2]) ? miso_s[2] : miso_l;

  // ==========================================================
  // serial engine
  logic [1:0] div_reg;     // half period divider
  logic [5:0] h_reg;       // half periods in the current state
  logic [25:0] sh_reg;     // outgoing frame
  logic sck_reg, ss_reg, mosi_reg;
  logic half;
  logic [5:0] h_next;
  assign half = (div_reg == 2'(SCK_HALF - 1));
  assign h_next = h_reg + 6'h1;
  assign spi.sck = sck_reg;
  assign spi.ss_n = ss_reg;
  assign spi.mosi = mosi_reg;

  // divider runs only outside idle, from select to the end of the gap
  always_ff @(posedge clk_i) begin
    if (rst_i || st_reg == H_IDLE)
      div_reg <= 2'h0;
    else
      div_reg <= half ? 2'h0 : div_reg + 2'h1;
  end

  // sequence: select, lead period, 26 bits, tail period, gap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= H_IDLE;
      h_reg <= 6'h0;
      sh_reg <= 26'h0;
      sck_reg <= 1'b0;
      ss_reg <= 1'b1;
      mosi_reg <= 1'b0;
      rdata_reg <= 16'h0;
    end else begin
      unique case (st_reg)
        H_IDLE: if (start) begin
          st_reg <= H_LEAD;
          ss_reg <= 1'b0;
          h_reg <= 6'h0;
          sh_reg <= {wb_dat_i[8:0], wb_dat_i[CMD_WE_BIT],
                     wb_dat_i[CMD_WE_BIT] ? wdata_reg : 16'h0};
        end
        H_LEAD: if (half) begin
          h_reg <= h_next;
          if (h_next == 6'(LEAD_HALVES)) begin
            st_reg <= H_BITS;
            h_reg <= 6'h0;
            mosi_reg <= sh_reg[25];  // msb first
          end
        end
        H_BITS: if (half) begin
          h_reg <= h_next;
          if (h_next[0]) begin
            sck_reg <= 1'b1;
          end else begin
            sck_reg <= 1'b0;
            // sample on the fall, skipping the first after the command
            if (!cmd_reg[CMD_WE_BIT] && h_next[5:1] >= 5'(RD_FIRST_FALL))
              rdata_reg <= {rdata_reg[14:0], miso_ag};
            if (h_next[5:1] == 5'(FRAME_BITS)) begin
              st_reg <= H_TAIL;
              h_reg <= 6'h0;
              mosi_reg <= 1'b0;
            end else begin
              sh_reg <= {sh_reg[24:0], 1'b0};
              mosi_reg <= sh_reg[24];
            end
          end
        end
        H_TAIL: if (half) begin
          h_reg <= h_next;
          if (h_next == 6'(TAIL_HALVES)) begin
            st_reg <= H_GAP;
            h_reg <= 6'h0;
            ss_reg <= 1'b1;
          end
        end
        H_GAP: if (half) begin
          h_reg <= h_next;
          if (h_next == 6'(GAP_HALVES))
            st_reg <= H_IDLE;
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  // done sets at the end of the gap, clears on a new command
  always_ff @(posedge clk_i) begin
    if (rst_i)
      done_reg <= 1'b0;
    else if (st_reg == H_GAP && half && h_next == 6'(GAP_HALVES))
      done_reg <= 1'b1;
    else if (start)
      done_reg <= 1'b0;
  end
endmodule : blc_host

// ==== blc_props.sv ====
// Purpose: wire-level checks on the serial link between host and sensor
// Assumes: host timing per the package half-period figures
// Notes: watches the interface signals only
`timescale 1ns/1ps
module blc_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic miso_line
);
  // ==========================================================
  // helper: rising sck edges within one selection
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] rises_reg; // cleared while deselected
  always_ff @(posedge clk_i) begin
    if (rst_i || ss_n) rises_reg <= 5'h0;
    else if ($rose(sck)) rises_reg <= rises_reg + 5'h1;
  end
  // ==========================================================
  // link assertions
  a_idle_clock: assert property (ss_n |-> !sck)
    else $error("sck toggles while deselected");
  a_lead_wait: assert property ($fell(ss_n) |-> !sck [*8] ##[3:5] sck)
    else $error("first sck rise not one period after select");
  a_tail_wait: assert property ($rose(ss_n) |-> !$past(sck) && !$past(sck, 8) && $past(sck, 9))
    else $error("deselect not one period after last bit");
  a_gap_hold: assert property ($rose(ss_n) |-> ss_n [*8] ##1 ss_n [*8])
    else $error("select gap shorter than two periods");
  a_frame_bits: assert property ($rose(ss_n) |-> rises_reg == 5'h1a)
    else $error("frame not 26 bits long");
  a_mosi_launch: assert property (!ss_n && sck && $past(sck) |-> $stable(mosi))
    else $error("mosi changed while sck high");
  a_miso_release: assert property (ss_n [*6] |-> miso_oe_n)
    else $error("miso driven while deselected");
  a_miso_settled: assert property (!miso_oe_n && $past(!miso_oe_n) && $fell(sck) |-> $stable(miso))
    else $error("miso moving at sampling edge");
  a_line_idle: assert property (miso_oe_n |-> !miso_line)
    else $error("miso line not idle while released");
endmodule : blc_props

// ==== blc_tb.sv ====
// Purpose: self-checking bench for host and sensor joined by the serial link
// Assumes: manual offset frames use two black lines, first gated
// Notes: reads and pixels are checked against queued expectations
`timescale 1ns/1ps
module blc_tb;
  import blc_pkg::*;
  `define CHK(n, g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
  // ==========================================================
  // stimulus and observation signals
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, want = 1'b0;
  logic fs = 1'b0, pv = 1'b0, wb_ack_o, pix_valid_o, black_line_o, blank_o;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, er, wb_dat_o;
  logic [9:0] px = 10'h0, pix_o, p;
  logic [11:0] ep;
  logic [15:0] v;
  logic [31:0] qr[$]; // expected wishbone read data
  logic [11:0] qp[$]; // expected {black, blank, pixel}
  int num_errors = 0, n_checks = 0, seed = 32'h0f4a, cyc_n = 0, i;
  blc_spi_if blc_spi_if_inst();
  blc_host blc_host_inst(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .spi(blc_spi_if_inst));
  blc_sensor blc_sensor_inst(.clk_i(clk_i), .rst_i(rst_i), .spi(blc_spi_if_inst),
    .frame_start_i(fs), .pix_valid_i(pv), .pix_i(px), .pix_valid_o(pix_valid_o),
    .pix_o(pix_o), .black_line_o(black_line_o), .blank_o(blank_o));
  blc_props blc_props_inst(.clk_i(clk_i), .rst_i(rst_i), .sck(blc_spi_if_inst.sck),
    .ss_n(blc_spi_if_inst.ss_n), .mosi(blc_spi_if_inst.mosi), .miso(blc_spi_if_inst.miso),
    .miso_oe_n(blc_spi_if_inst.miso_oe_n), .miso_line(blc_spi_if_inst.miso_line));
  // ==========================================================
  // clock, hang guard, result monitor
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin // about a third above the expected run
      num_errors++;
      complete_run();
    end
  end
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && want) begin
      er = qr.pop_front();
      `CHK("rdata", wb_dat_o, er)
    end
    if (pix_valid_o === 1'b1) begin
      ep = qp.pop_front();
      `CHK("pixel", {black_line_o, blank_o, pix_o}, ep)
    end
  end
  // ==========================================================
  // bus tasks
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1); // request held until ack
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask : wb
  task rdw(input logic [3:0] a, input logic [31:0] e);
    qr.push_back(e);
    want <= 1'b1;
    wb(1'b0, a, 32'h0);
    want <= 1'b0;
  endtask : rdw
  task acc(input logic [8:0] r, input logic w, input logic [15:0] d);
    wb(1'b1, WB_WDATA, {16'h0, d});
    wb(1'b1, WB_CMD, {22'h0, w, r});
    do wb(1'b0, WB_STATUS, 32'h0); while (rd[ST_DONE] !== 1'b1); // poll for done
  endtask : acc
  task chk_reg(input logic [8:0] r, input logic [15:0] e);
    acc(r, 1'b0, 16'h0);
    rdw(WB_RDATA, {16'h0, e});
  endtask : chk_reg
  // one frame: gated line, raw line, then corrected pixels; k is the expected offset
  task frame(input logic au, input logic sub, input logic [8:0] off, input logic [9:0] c,
    input logic [9:0] k);
    logic [10:0] s;
    acc(REG_OFFS, 1'b1, {5'h0, sub, off, au});
    @(posedge clk_i);
    fs <= 1'b1;
    for (i = 0; i < 10248; i++) begin
      @(posedge clk_i);
      p = 10'($random(seed));
      if (au && i >= 5120 && i < 10240) p = c; // flat black level for auto frames
      fs <= 1'b0;
      pv <= 1'b1;
      px <= p;
      s = sub ? {1'b0, p} - k : {1'b0, p} + k;
      if (i < 5120) qp.push_back(12'hc00);
      else if (i < 10240) qp.push_back({2'b10, p});
      else qp.push_back({2'b00, s[10] ? (sub ? 10'h0 : PIX_MAX) : s[9:0]});
    end
    @(posedge clk_i);
    pv <= 1'b0;
  endtask : frame
  task complete_run;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdw(4'h2, 32'h0); // unmapped host address
    chk_reg(REG_FILT, FILT_RST);
    chk_reg(REG_OFFS, OFFS_RST);
    chk_reg(REG_LINES, LINES_RST);
    chk_reg(REG_ERR3, 16'h0);
    v = 16'($random(seed));
    acc(REG_FILT, 1'b1, v);
    chk_reg(REG_FILT, v);
    acc(REG_ERR0, 1'b1, 16'hffff); // read-only, must stay clear
    chk_reg(REG_ERR0, 16'h0);
    acc(REG_LINES, 1'b1, 16'h0102); // two lines, first gated
    chk_reg(REG_LINES, 16'h0102);
    v = 16'($random(seed));
    frame(1'b0, 1'b0, v[8:0], 10'h0, {1'b0, v[8:0]});
    frame(1'b0, 1'b1, v[15:7], 10'h0, {1'b0, v[15:7]});
    acc(REG_FILT, 1'b1, 16'h0000); // one sample, avg lands on it
    frame(1'b1, 1'b1, 9'h0, v[9:0], v[9:0]);
    chk_reg(REG_ERR1, 16'h0);
    acc(REG_FILT, 1'b1, 16'h0600); // 64 samples, above the cap
    frame(1'b1, 1'b1, FREEZE_CODE, ~v[9:0], v[9:0]);
    chk_reg(REG_ERR0, 16'hffff);
    chk_reg(REG_ERR3, 16'hffff);
    repeat (4) @(posedge clk_i);
    `CHK("queued", qp.size() + qr.size(), 0)
    complete_run();
  end
endmodule : blc_tb
